//--- design/tfa_pkg.sv
// package for the tributary formatter and alarm control block
// assumes a 16-bit host control port addressed in bytes, one clock domain
package tfa_pkg;

  // =====================================================================
  // sizes
  localparam int TRIB_COUNT  = 7;   // second-order tributaries
  localparam int E2_COUNT    = 4;   // tributaries in E3 operation
  localparam int T1E1_COUNT  = 28;  // low-order streams under forcing
  localparam int FORCE1_W    = 16;  // streams held in the first force register
  localparam int FORCE2_W    = 12;  // streams held in the second force register
  localparam int LOF_FRAMES  = 4;   // frames corrupted per injection

  // =====================================================================
  // register offsets (byte addresses of 16-bit registers)
  localparam logic [7:0] MASTER_ID_CONTROL_OFS           = 8'h02;
  localparam logic [7:0] TRIBUTARY_TX_ALARM_CONTROL_OFS  = 8'h30;
  localparam logic [7:0] TRIBUTARY_TX_INJECT_CONTROL_OFS = 8'h32;
  localparam logic [7:0] TRIBUTARY_STATUS_TWO_OFS        = 8'h36;
  localparam logic [7:0] RX_TRIBUTARY_ALLONES_FORCE_1_OFS = 8'h40;
  localparam logic [7:0] RX_TRIBUTARY_ALLONES_FORCE_2_OFS = 8'h42;
  localparam logic [7:0] TX_TRIBUTARY_ALLONES_FORCE_1_OFS = 8'h44;
  localparam logic [7:0] TX_TRIBUTARY_ALLONES_FORCE_2_OFS = 8'h46;

  // =====================================================================
  // field positions
  localparam int RAI_POS      = 0;   // tx_remote_alarm_n, bits 0..6
  localparam int AIS_POS      = 8;   // tx_alarm_all_ones_n, bits 8..14
  localparam int LOF_POS      = 0;   // frame_loss_inject_n, bits 0..6
  localparam int NAT_POS      = 8;   // national_spare_bit_n, bits 8..11
  localparam int SR_RAI_POS   = 0;   // received remote alarm latches
  localparam int SR_IE_POS    = 7;   // remote alarm interrupt enable
  localparam int SR_NAT_POS   = 8;   // received national bits
  localparam int SR_SOF_POS   = 12;  // received start of frame latches
  localparam int RESYNC_POS   = 0;   // tributary_resync_request

  // =====================================================================
  // reset values
  localparam logic [15:0] ALARM_CTL_RST  = 16'h0000;
  localparam logic [15:0] INJECT_CTL_RST = 16'h0000;
  localparam logic [15:0] FORCE1_RST     = 16'hffff;
  localparam logic [11:0] FORCE2_RST     = 12'hfff;

  // =====================================================================
  // types
  typedef enum logic [2:0] {
    MODE_T3   = 3'b001,
    MODE_E3   = 3'b010,
    MODE_G747 = 3'b100
  } tfa_mode_type;

  // per-tributary formatter steering, applied from a frame boundary
  typedef struct packed {
    logic all_ones;    // replace frame with unframed all ones
    logic alarm_bit;   // value to send in the remote alarm position
    logic fas_invert;  // invert framing bits in this frame
    logic nat_bit;     // national bit value to send
  } tfa_tx_ctl_type;

endpackage

//--- design/tfa_trib_ctl.sv
// per-tributary formatter steering: frame-aligned alarms and loss injection
// assumes frame_start pulses one cycle at each outgoing frame boundary
`timescale 1ns/1ps

module tfa_trib_ctl (
  input  wire logic                    clk,
  input  wire logic                    rst,
  input  wire tfa_pkg::tfa_mode_type   mode,
  input  wire logic                    frame_start,
  input  wire logic                    rai_set,
  input  wire logic                    ais_set,
  input  wire logic                    inject_set,
  input  wire logic                    nat_set,
  output tfa_pkg::tfa_tx_ctl_type      ctl
);

  // =====================================================================
  // state
  tfa_pkg::tfa_tx_ctl_type ctl_r, ctl_nxt;
  logic       inj_prev_r, inj_prev_nxt;
  logic       pend_r, pend_nxt;
  logic [2:0] left_r, left_nxt;

  // next values: edge capture anywhere, apply only at frame start
  always_comb begin
    inj_prev_nxt = inject_set;
    pend_nxt     = pend_r | (inject_set & ~inj_prev_r);
    left_nxt     = left_r;
    ctl_nxt      = ctl_r;
    if (frame_start) begin
      if (left_r != 3'h0) begin
        left_nxt = left_r - 3'h1;
      end else if (pend_r) begin
        left_nxt = 3'(tfa_pkg::LOF_FRAMES - 1);
        pend_nxt = inject_set & ~inj_prev_r;
      end
      ctl_nxt.fas_invert = (left_r != 3'h0) || pend_r;
      ctl_nxt.all_ones   = ais_set;
      if (mode == tfa_pkg::MODE_T3) begin
        ctl_nxt.alarm_bit = ~rai_set;
      end else begin
        ctl_nxt.alarm_bit = rai_set;
      end
      if (mode == tfa_pkg::MODE_E3) begin
        ctl_nxt.nat_bit = nat_set;
      end else begin
        ctl_nxt.nat_bit = 1'b1;
      end
    end
  end

  // registers
  always_ff @(posedge clk) begin
    if (rst) begin
      ctl_r      <= '0;
      inj_prev_r <= 1'b0;
      pend_r     <= 1'b0;
      left_r     <= 3'h0;
    end else begin
      ctl_r      <= ctl_nxt;
      inj_prev_r <= inj_prev_nxt;
      pend_r     <= pend_nxt;
      left_r     <= left_nxt;
    end
  end

  assign ctl = ctl_r;

endmodule

//--- design/tfa_top.sv
// tributary formatter and alarm control: host registers and per-tributary steering
// assumes a synchronous 16-bit host port, inputs synchronous to clk
//
// Notes on behaviour
// - all-ones forcing per T1/E1 stream, both directions
// - reset forces all-ones on every stream
// - T3: alarm setting one sends X zero
// - E3: bit 11 follows alarm setting
// - G.747: set 2 bit 1 follows alarm
// - all-ones setting replaces frame with ones
// - rising inject setting causes framing error burst
// - one burst per rising edge only
// - T3: four consecutive frames of F errors
// - E3: inverted alignment word four frames
// - G.747: inverted nine-bit word four frames
// - E3: national bit follows its setting
// - national settings ignored in T3, G.747
// - received national bits readable in status
// - receive framers align and monitor streams
// - resync request forces receive framers realign
// - received national bit updated each frame start
`timescale 1ns/1ps

module tfa_top (
  input  wire logic                                   clk,
  input  wire logic                                   rst,
  input  wire logic [7:0]                             host_addr,
  input  wire logic [15:0]                            host_wdata,
  input  wire logic                                   host_wr,
  input  wire logic                                   host_rd,
  output logic [15:0]                                 host_rdata,
  output logic                                        host_rvalid,
  input  wire tfa_pkg::tfa_mode_type                  mux_mode,
  input  wire logic [tfa_pkg::TRIB_COUNT-1:0]         tx_frame_start,
  input  wire logic [tfa_pkg::E2_COUNT-1:0]           rx_e2_sof,
  input  wire logic [tfa_pkg::E2_COUNT-1:0]           rx_e2_nat,
  input  wire logic [tfa_pkg::TRIB_COUNT-1:0]         rx_rai_alarm,
  output tfa_pkg::tfa_tx_ctl_type [tfa_pkg::TRIB_COUNT-1:0] tx_ctl,
  output logic                                        rx_resync,
  output logic [tfa_pkg::T1E1_COUNT-1:0]              rx_trib_allones_force,
  output logic [tfa_pkg::T1E1_COUNT-1:0]              tx_trib_allones_force
);

  // =====================================================================
  // control registers
  logic [15:0] alarm_ctl_r;
  logic [15:0] alarm_ctl_nxt;
  logic [15:0] inject_ctl_r;
  logic [15:0] inject_ctl_nxt;
  logic [15:0] rx_force1_r;
  logic [15:0] rx_force1_nxt;
  logic [11:0] rx_force2_r;
  logic [11:0] rx_force2_nxt;
  logic [15:0] tx_force1_r;
  logic [15:0] tx_force1_nxt;
  logic [11:0] tx_force2_r;
  logic [11:0] tx_force2_nxt;
  logic        resync_r;
  logic        resync_nxt;

  // writable bit masks: reserved bits never store
  localparam logic [15:0] ALARM_MASK  = 16'h7f7f;
  localparam logic [15:0] INJECT_MASK = 16'h0f7f;

  // strobe qualified by one register offset, for writes and reads
  function automatic logic wr_hit(input logic [7:0] addr, input logic wr, input logic [7:0] ofs);
    wr_hit = wr && (addr == ofs);
  endfunction

  // widen a twelve-stream force register to the read word
  function automatic logic [15:0] pad_force2(input logic [11:0] streams);
    pad_force2 = {4'h0, streams};
  endfunction

  // =====================================================================
  // register selects: one per mapped offset for writes, one per offset except the master register for reads
  logic wr_alarm;
  logic wr_inject;
  logic wr_rx_force1;
  logic wr_rx_force2;
  logic wr_tx_force1;
  logic wr_tx_force2;
  logic wr_master;
  logic wr_status_two;
  logic rd_alarm;
  logic rd_inject;
  logic rd_status_two;
  logic rd_rx_force1;
  logic rd_rx_force2;
  logic rd_tx_force1;
  logic rd_tx_force2;

  // write selects
  assign wr_alarm      = wr_hit(host_addr, host_wr, tfa_pkg::TRIBUTARY_TX_ALARM_CONTROL_OFS);
  assign wr_inject     = wr_hit(host_addr, host_wr, tfa_pkg::TRIBUTARY_TX_INJECT_CONTROL_OFS);
  assign wr_rx_force1  = wr_hit(host_addr, host_wr, tfa_pkg::RX_TRIBUTARY_ALLONES_FORCE_1_OFS);
  assign wr_rx_force2  = wr_hit(host_addr, host_wr, tfa_pkg::RX_TRIBUTARY_ALLONES_FORCE_2_OFS);
  assign wr_tx_force1  = wr_hit(host_addr, host_wr, tfa_pkg::TX_TRIBUTARY_ALLONES_FORCE_1_OFS);
  assign wr_tx_force2  = wr_hit(host_addr, host_wr, tfa_pkg::TX_TRIBUTARY_ALLONES_FORCE_2_OFS);
  assign wr_master     = wr_hit(host_addr, host_wr, tfa_pkg::MASTER_ID_CONTROL_OFS);
  assign wr_status_two = wr_hit(host_addr, host_wr, tfa_pkg::TRIBUTARY_STATUS_TWO_OFS);

  // read selects share the same decode
  assign rd_alarm      = wr_hit(host_addr, host_rd, tfa_pkg::TRIBUTARY_TX_ALARM_CONTROL_OFS);
  assign rd_inject     = wr_hit(host_addr, host_rd, tfa_pkg::TRIBUTARY_TX_INJECT_CONTROL_OFS);
  assign rd_status_two = wr_hit(host_addr, host_rd, tfa_pkg::TRIBUTARY_STATUS_TWO_OFS);
  assign rd_rx_force1  = wr_hit(host_addr, host_rd, tfa_pkg::RX_TRIBUTARY_ALLONES_FORCE_1_OFS);
  assign rd_rx_force2  = wr_hit(host_addr, host_rd, tfa_pkg::RX_TRIBUTARY_ALLONES_FORCE_2_OFS);
  assign rd_tx_force1  = wr_hit(host_addr, host_rd, tfa_pkg::TX_TRIBUTARY_ALLONES_FORCE_1_OFS);
  assign rd_tx_force2  = wr_hit(host_addr, host_rd, tfa_pkg::TX_TRIBUTARY_ALLONES_FORCE_2_OFS);

  // control register next values
  always_comb begin
    alarm_ctl_nxt  = alarm_ctl_r;
    inject_ctl_nxt = inject_ctl_r;
    rx_force1_nxt  = rx_force1_r;
    rx_force2_nxt  = rx_force2_r;
    tx_force1_nxt  = tx_force1_r;
    tx_force2_nxt  = tx_force2_r;
    resync_nxt     = 1'b0;  // one-cycle request pulse
    if (wr_alarm) begin
      alarm_ctl_nxt = host_wdata & ALARM_MASK;
    end else if (wr_inject) begin
      inject_ctl_nxt = host_wdata & INJECT_MASK;
    end else if (wr_rx_force1) begin
      rx_force1_nxt = host_wdata;
    end else if (wr_rx_force2) begin
      rx_force2_nxt = host_wdata[11:0];
    end else if (wr_tx_force1) begin
      tx_force1_nxt = host_wdata;
    end else if (wr_tx_force2) begin
      tx_force2_nxt = host_wdata[11:0];
    end else if (wr_master) begin
      resync_nxt = host_wdata[tfa_pkg::RESYNC_POS];
    end
  end

  // control registers
  always_ff @(posedge clk) begin
    if (rst) begin
      alarm_ctl_r  <= tfa_pkg::ALARM_CTL_RST;
      inject_ctl_r <= tfa_pkg::INJECT_CTL_RST;
      rx_force1_r  <= tfa_pkg::FORCE1_RST;
      rx_force2_r  <= tfa_pkg::FORCE2_RST;
      tx_force1_r  <= tfa_pkg::FORCE1_RST;
      tx_force2_r  <= tfa_pkg::FORCE2_RST;
      resync_r     <= 1'b0;
    end else begin
      alarm_ctl_r  <= alarm_ctl_nxt;
      inject_ctl_r <= inject_ctl_nxt;
      rx_force1_r  <= rx_force1_nxt;
      rx_force2_r  <= rx_force2_nxt;
      tx_force1_r  <= tx_force1_nxt;
      tx_force2_r  <= tx_force2_nxt;
      resync_r     <= resync_nxt;
    end
  end

  assign rx_trib_allones_force = {rx_force2_r, rx_force1_r};
  assign tx_trib_allones_force = {tx_force2_r, tx_force1_r};
  assign rx_resync             = resync_r;

  // =====================================================================
  // receive status: remote alarm latches, national bits, frame starts
  logic [tfa_pkg::TRIB_COUNT-1:0] rai_lat_r;
  logic [tfa_pkg::TRIB_COUNT-1:0] rai_lat_nxt;
  logic                           ie_rai_r;
  logic                           ie_rai_nxt;
  logic [tfa_pkg::E2_COUNT-1:0]   nat_rx_r;
  logic [tfa_pkg::E2_COUNT-1:0]   nat_rx_nxt;
  logic [tfa_pkg::E2_COUNT-1:0]   sof_lat_r;
  logic [tfa_pkg::E2_COUNT-1:0]   sof_lat_nxt;
  logic                           sr2_read;

  assign sr2_read = rd_status_two;

  // latches clear on read; a new event in the same cycle wins
  always_comb begin
    rai_lat_nxt = (sr2_read ? '0 : rai_lat_r) | rx_rai_alarm;
    sof_lat_nxt = (sr2_read ? '0 : sof_lat_r) | rx_e2_sof;
    ie_rai_nxt  = ie_rai_r;
    if (wr_status_two) begin
      ie_rai_nxt = host_wdata[tfa_pkg::SR_IE_POS];
    end
    nat_rx_nxt = nat_rx_r;
    for (int i = 0; i < tfa_pkg::E2_COUNT; i++) begin
      if (rx_e2_sof[i]) begin
        nat_rx_nxt[i] = rx_e2_nat[i];
      end
    end
  end

  // status registers
  always_ff @(posedge clk) begin
    if (rst) begin
      rai_lat_r <= '0;
      ie_rai_r  <= 1'b0;
      nat_rx_r  <= '0;
      sof_lat_r <= '0;
    end else begin
      rai_lat_r <= rai_lat_nxt;
      ie_rai_r  <= ie_rai_nxt;
      nat_rx_r  <= nat_rx_nxt;
      sof_lat_r <= sof_lat_nxt;
    end
  end

  // =====================================================================
  // host read path, data one cycle after the strobe
  logic [15:0] rdata_r;
  logic [15:0] rdata_nxt;
  logic        rvalid_r;
  logic        rvalid_nxt;
  logic [15:0] status_two_word;

  // status word: frame starts, national bits, enable, alarms
  assign status_two_word = {sof_lat_r, nat_rx_r, ie_rai_r, rai_lat_r};

  // read mux; unmapped offsets read zero
  always_comb begin
    rvalid_nxt = host_rd;
    rdata_nxt  = 16'h0000;
    if (!host_rd) begin
      rdata_nxt = 16'h0000;
    end else if (rd_alarm) begin
      rdata_nxt = alarm_ctl_r;
    end else if (rd_inject) begin
      rdata_nxt = inject_ctl_r;
    end else if (rd_status_two) begin
      rdata_nxt = status_two_word;
    end else if (rd_rx_force1) begin
      rdata_nxt = rx_force1_r;
    end else if (rd_rx_force2) begin
      rdata_nxt = pad_force2(rx_force2_r);
    end else if (rd_tx_force1) begin
      rdata_nxt = tx_force1_r;
    end else if (rd_tx_force2) begin
      rdata_nxt = pad_force2(tx_force2_r);
    end
  end

  // read registers
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_r  <= 16'h0000;
      rvalid_r <= 1'b0;
    end else begin
      rdata_r  <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
    end
  end

  assign host_rdata  = rdata_r;
  assign host_rvalid = rvalid_r;

  // =====================================================================
  // per-tributary views of the transmit settings
  logic [tfa_pkg::TRIB_COUNT-1:0] rai_setting;
  logic [tfa_pkg::TRIB_COUNT-1:0] ais_setting;
  logic [tfa_pkg::TRIB_COUNT-1:0] lof_setting;
  logic [tfa_pkg::E2_COUNT-1:0]   nat_field;

  // alarm register fields
  assign rai_setting = alarm_ctl_r[tfa_pkg::RAI_POS +: tfa_pkg::TRIB_COUNT];
  assign ais_setting = alarm_ctl_r[tfa_pkg::AIS_POS +: tfa_pkg::TRIB_COUNT];

  // inject register fields; national bits exist for four tributaries only
  assign lof_setting = inject_ctl_r[tfa_pkg::LOF_POS +: tfa_pkg::TRIB_COUNT];
  assign nat_field   = inject_ctl_r[tfa_pkg::NAT_POS +: tfa_pkg::E2_COUNT];

  // =====================================================================
  // per-tributary formatter steering
  for (genvar t = 0; t < tfa_pkg::TRIB_COUNT; t++) begin : g_trib
    logic nat_setting;

    // only the first four tributaries carry a national bit
    if (t < tfa_pkg::E2_COUNT) begin : g_nat
      assign nat_setting = nat_field[t];
    end else begin : g_nonat
      assign nat_setting = 1'b1;
    end

    tfa_trib_ctl u_ctl (
      .clk         (clk),
      .rst         (rst),
      .mode        (mux_mode),
      .frame_start (tx_frame_start[t]),
      .rai_set     (rai_setting[t]),
      .ais_set     (ais_setting[t]),
      .inject_set  (lof_setting[t]),
      .nat_set     (nat_setting),
      .ctl         (tx_ctl[t])
    );
  end

endmodule

//--- testbench/tfa_checker.sv
// concurrent checks on the tributary control block ports
// assumes binding onto tfa_top, one clock, synchronous reset
`timescale 1ns/1ps

module tfa_checker (
  input wire logic                                          clk,
  input wire logic                                          rst,
  input wire logic [7:0]                                    host_addr,
  input wire logic [15:0]                                   host_wdata,
  input wire logic                                          host_wr,
  input wire logic                                          host_rd,
  input wire logic [15:0]                                   host_rdata,
  input wire logic                                          host_rvalid,
  input wire tfa_pkg::tfa_mode_type                         mux_mode,
  input wire logic [tfa_pkg::TRIB_COUNT-1:0]                tx_frame_start,
  input wire logic [tfa_pkg::E2_COUNT-1:0]                  rx_e2_sof,
  input wire logic [tfa_pkg::E2_COUNT-1:0]                  rx_e2_nat,
  input wire logic [tfa_pkg::TRIB_COUNT-1:0]                rx_rai_alarm,
  input wire tfa_pkg::tfa_tx_ctl_type [tfa_pkg::TRIB_COUNT-1:0] tx_ctl,
  input wire logic                                          rx_resync,
  input wire logic [tfa_pkg::T1E1_COUNT-1:0]                rx_trib_allones_force,
  input wire logic [tfa_pkg::T1E1_COUNT-1:0]                tx_trib_allones_force
);
  // ======================================================================
  // shadow of the transmit settings
  logic [15:0] alarm_r, alarm_nxt, inject_r, inject_nxt;

  // shadow next values from host writes
  always_comb begin
    alarm_nxt = rst ? 16'h0000 : alarm_r;
    inject_nxt = rst ? 16'h0000 : inject_r;
    if (!rst && host_wr && host_addr == tfa_pkg::TRIBUTARY_TX_ALARM_CONTROL_OFS) alarm_nxt = host_wdata & 16'h7f7f;
    if (!rst && host_wr && host_addr == tfa_pkg::TRIBUTARY_TX_INJECT_CONTROL_OFS) inject_nxt = host_wdata & 16'h0f7f;
  end

  // shadow registers
  always_ff @(posedge clk) begin
    alarm_r <= alarm_nxt;
    inject_r <= inject_nxt;
  end

  // ======================================================================
  // properties
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_resync_req;
    host_wr && host_addr == tfa_pkg::MASTER_ID_CONTROL_OFS && host_wdata[0];
  endsequence
  sequence s_resync_pulse;
    rx_resync ##1 !rx_resync;
  endsequence
  sequence s_read_answer;
    host_rvalid ##1 !host_rvalid;
  endsequence
  property p_resync;
    s_resync_req |=> s_resync_pulse;
  endproperty

  a_reset_forcing: assert property ($past(rst) |-> (&rx_trib_allones_force) && (&tx_trib_allones_force))
    else $error("force buses not all ones after reset");
  a_reset_ctl_zero: assert property ($past(rst) |-> tx_ctl == '0 && !host_rvalid)
    else $error("steering not cleared by reset");
  a_ctl_frame_only: assert property ($past(tx_frame_start) == '0 |-> $stable(tx_ctl))
    else $error("steering changed between frame boundaries");
  a_all_ones_follow: assert property (tx_frame_start[0] |=> tx_ctl[0].all_ones == $past(alarm_r[8]))
    else $error("all ones steering wrong");
  a_alarm_by_mode: assert property (tx_frame_start[0] |=>
    tx_ctl[0].alarm_bit == ($past(alarm_r[0]) ^ ($past(mux_mode) == tfa_pkg::MODE_T3)))
    else $error("remote alarm bit wrong for mode");
  a_nat_by_mode: assert property (tx_frame_start[0] |=>
    tx_ctl[0].nat_bit == ($past(mux_mode) != tfa_pkg::MODE_E3 || $past(inject_r[8])))
    else $error("national bit wrong for mode");
  a_resync_pulse: assert property (p_resync)
    else $error("resync pulse missing or too long");
  a_read_answer: assert property (host_rd |=> s_read_answer)
    else $error("read answer not a single pulse");
  a_force_write: assert property (host_wr && host_addr == tfa_pkg::TX_TRIBUTARY_ALLONES_FORCE_1_OFS
    |=> tx_trib_allones_force[15:0] == $past(host_wdata))
    else $error("transmit force bus not updated");
endmodule

bind tfa_top tfa_checker tfa_checker_inst (.clk(clk), .rst(rst), .host_addr(host_addr), .host_wdata(host_wdata),
  .host_wr(host_wr), .host_rd(host_rd), .host_rdata(host_rdata), .host_rvalid(host_rvalid), .mux_mode(mux_mode),
  .tx_frame_start(tx_frame_start), .rx_e2_sof(rx_e2_sof), .rx_e2_nat(rx_e2_nat), .rx_rai_alarm(rx_rai_alarm),
  .tx_ctl(tx_ctl), .rx_resync(rx_resync), .rx_trib_allones_force(rx_trib_allones_force),
  .tx_trib_allones_force(tx_trib_allones_force));

//--- testbench/tfa_far_end.sv
// far-end framer model: frame boundaries, received national and alarm bits
// assumes one clock shared with the block, synchronous active-high reset
`timescale 1ns/1ps

module tfa_far_end #(
  parameter int FRAME_LEN = 16
) (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic [3:0]  nat_in,
  input wire logic [6:0]  rai_in,
  output logic     [6:0]  frame_start,
  output logic     [3:0]  e2_sof,
  output logic     [3:0]  e2_nat,
  output logic     [6:0]  rai_alarm
);
  int cnt = 0;

  // quiet outputs before the first edge
  initial {frame_start, e2_sof, e2_nat, rai_alarm} = '0;

  // aligned frame counter; national bit only valid with the boundary
  always @(posedge clk) begin
    cnt <= (rst || cnt == FRAME_LEN - 1) ? 0 : cnt + 1;
    frame_start <= {7{!rst && cnt == 0}};
    e2_sof <= {4{!rst && cnt == 0}};
    e2_nat <= (!rst && cnt == 0) ? nat_in : ~nat_in;
    rai_alarm <= rai_in;
  end
endmodule

//--- testbench/testbench.sv
// self-checking bench for the tributary control block
// assumes tfa_pkg compiled first and the checker bound onto tfa_top
`timescale 1ns/1ps

module testbench;
  logic                           clk, rst, host_wr, host_rd, host_rvalid, rx_resync, f;
  logic [7:0]                     host_addr;
  logic [15:0]                    host_rdata, host_wdata, al, inj;
  logic [3:0]                     rx_e2_sof, rx_e2_nat, nat_in;
  logic [6:0]                     tx_frame_start, rx_rai_alarm, rai_in;
  logic [27:0]                    rx_force, tx_force;
  logic [31:0]                    lfsr;
  tfa_pkg::tfa_mode_type          mux_mode;
  tfa_pkg::tfa_tx_ctl_type [6:0]  tx_ctl;
  logic [15:0]                    exp_q[$];
  int                             error_cnt, checks_done, n;
  logic [7:0]                     ofs[7] = '{8'h30, 8'h32, 8'h40, 8'h42, 8'h44, 8'h46, 8'h50};
  logic [15:0]                    rv[7] = '{16'h0000, 16'h0000, 16'hffff, 16'h0fff, 16'hffff, 16'h0fff, 16'h0000};
  tfa_pkg::tfa_mode_type          modes[3] = '{tfa_pkg::MODE_T3, tfa_pkg::MODE_E3, tfa_pkg::MODE_G747};

  tfa_top tfa_top_inst (.clk(clk), .rst(rst), .host_addr(host_addr), .host_wdata(host_wdata), .host_wr(host_wr),
    .host_rd(host_rd), .host_rdata(host_rdata), .host_rvalid(host_rvalid), .mux_mode(mux_mode),
    .tx_frame_start(tx_frame_start), .rx_e2_sof(rx_e2_sof), .rx_e2_nat(rx_e2_nat), .rx_rai_alarm(rx_rai_alarm),
    .tx_ctl(tx_ctl), .rx_resync(rx_resync), .rx_trib_allones_force(rx_force), .tx_trib_allones_force(tx_force));
  tfa_far_end tfa_far_end_inst (.clk(clk), .rst(rst), .nat_in(nat_in), .rai_in(rai_in),
    .frame_start(tx_frame_start), .e2_sof(rx_e2_sof), .e2_nat(rx_e2_nat), .rai_alarm(rx_rai_alarm));

  // ======================================================================
  // helpers
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("FAIL %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_sim;
    $display("errors %0d checks %0d", error_cnt, checks_done);
    if (error_cnt == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // one host strobe, held for exactly one sampling edge
  task automatic bus(input logic [7:0] a, input logic [15:0] d, input logic rd_op);
    @(posedge clk);
    host_addr <= a;
    host_wdata <= d;
    host_wr <= !rd_op;
    host_rd <= rd_op;
    @(posedge clk);
    host_wr <= 1'b0;
    host_rd <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    exp_q.push_back(e);
    bus(a, 16'h0000, 1'b1);
  endtask

  // wait for the next boundary of tributary 1, sample its steering after it
  task automatic next_frame(output logic fas);
    int i;
    for (i = 0; i < 40; i++) begin
      @(posedge clk);
      if (tx_frame_start[0] === 1'b1) break;
    end
    if (i == 40) begin
      error_cnt++;
      $display("FAIL %0t: no frame boundary", $time);
      end_sim();
    end
    #1;
    fas = tx_ctl[0].fas_invert;
  endtask

  // ======================================================================
  // clock and read answer monitor
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // compare every read answer with the oldest note
  always @(posedge clk) begin
    if (host_rvalid === 1'b1) chk(host_rdata, exp_q.size() > 0 ? exp_q.pop_front() : ~host_rdata);
  end

  // ======================================================================
  // main sequence
  initial begin
    {rst, host_wr, host_rd, host_addr, host_wdata} = {1'b1, 26'h0};
    {nat_in, rai_in, mux_mode} = {4'ha, 7'h55, tfa_pkg::MODE_T3};
    {error_cnt, checks_done, lfsr} = {32'h0, 32'h0, 32'h00012de7};
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    for (int k = 0; k < 7; k++) rd(ofs[k], rv[k]);
    chk({4'h0, tx_force}, 32'h0fffffff);
    chk({4'h0, tx_ctl}, 32'h05555555);
    for (int k = 2; k < 6; k++) bus(ofs[k], 16'h0000, 1'b0);
    @(posedge clk);
    #1;
    chk({4'h0, rx_force}, 32'h0);
    chk({4'h0, tx_force}, 32'h0);
    bus(tfa_pkg::MASTER_ID_CONTROL_OFS, 16'h0001, 1'b0);
    #1;
    chk(rx_resync, 1'b1);
    next_frame(f);
    next_frame(f);
    rd(tfa_pkg::TRIBUTARY_STATUS_TWO_OFS, {4'hf, 4'ha, 1'b0, 7'h55});
    for (int m = 0; m < 3; m++) begin
      @(posedge clk);
      mux_mode <= modes[m];
      lfsr = lfsr_next(lfsr);
      al = lfsr[15:0] & (modes[m] == tfa_pkg::MODE_E3 ? 16'h0f0f : 16'h7f7f);
      inj = {4'h0, lfsr[27:24], 8'h00};
      bus(8'h30, al, 1'b0);
      rd(8'h30, al);
      bus(8'h32, inj, 1'b0);
      rd(8'h32, inj);
      next_frame(f);
      next_frame(f);
      for (int t = 0; t < 7; t++) begin
        chk(tx_ctl[t].all_ones, al[8 + t]);
        chk(tx_ctl[t].alarm_bit, al[t] ^ (modes[m] == tfa_pkg::MODE_T3));
        chk(tx_ctl[t].nat_bit, (modes[m] == tfa_pkg::MODE_E3 && t < 4) ? inj[8 + t] : 1'b1);
      end
      bus(8'h32, inj | 16'h0001, 1'b0);
      n = 0;
      repeat (7) begin
        next_frame(f);
        if (f === 1'b1) n++;
      end
      chk(n, 4);
      n = 0;
      repeat (5) begin
        next_frame(f);
        if (f === 1'b1) n++;
      end
      chk(n, 0);
      bus(8'h32, inj, 1'b0);
    end
    repeat (4) @(posedge clk);
    end_sim();
  end
endmodule
